/* dv/sr_far_side.sv */
// Transformer winding seen through the sense dividers.
// Assumes fire is a one-cycle request; primary drops to zero after the pulse.
`default_nettype none
module sr_far_side (
    input wire logic clk,
    input wire logic fire,
    input wire logic [9:0] hi_level,
    input wire logic [15:0] hi_len,
    input wire logic [9:0] out_level,
    output logic [9:0] primary_sense,
    output logic [9:0] output_sense
);
    timeunit 1ns;
    timeprecision 100ps;
    int left = 0;
    initial begin
        primary_sense = 10'h000;
        output_sense = 10'h000;
    end
    // Body diode clamps the winding near zero once the pulse ends
    always @(posedge clk) begin
        if (fire)
            left = hi_len;
        primary_sense <= #1 (left > 0) ? hi_level : 10'h000;
        output_sense <= #1 out_level;
        if (left > 0)
            left = left - 1;
    end
endmodule
`default_nettype wire

/* dv/sr_on_time_ctrl_sva.sv */
// Checker for the rectifier gate controller, bound to its ports.
// Assumes one clock domain with an asynchronous active-low reset.
`default_nettype none
module sr_on_time_ctrl_sva #(
    parameter int ADC_W = 10,
    parameter int OFF_BLANK_CYC = 435
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADC_W-1:0] primary_sense,
    input wire logic [ADC_W-1:0] output_sense,
    input wire logic [ADC_W-1:0] primary_enable_level,
    input wire logic [ADC_W-1:0] output_enable_level,
    input wire logic [ADC_W-1:0] overvoltage_level,
    input wire logic [ADC_W-1:0] zero_level,
    input wire logic [3:0] blank_set_pin,
    input wire logic sr_gate_drive,
    input wire logic fault,
    input wire logic [ADC_W-1:0] dynamic_threshold
);
    int on_cnt;
    int off_cnt;
    int hi_cnt;
    int hi_len;
    int ov_cnt;
    ////////////////////////////////////////////////////////////
    // Raw pin counts; sync lag is absorbed by the margins below
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_cnt <= 0;
            off_cnt <= OFF_BLANK_CYC;
            hi_cnt <= 0;
            hi_len <= 0;
            ov_cnt <= 0;
        end else begin
            on_cnt <= sr_gate_drive ? on_cnt + 1 : 0;
            off_cnt <= sr_gate_drive ? 0 : (off_cnt < OFF_BLANK_CYC ? off_cnt + 1 : off_cnt);
            hi_cnt <= (primary_sense > primary_enable_level) ? hi_cnt + 1 : 0;
            if (hi_cnt != 0 && primary_sense <= primary_enable_level)
                hi_len <= hi_cnt;
            ov_cnt <= (primary_sense > overvoltage_level) ? ov_cnt + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_ON_AT_ZERO: assert property ($rose(sr_gate_drive) |-> $past(primary_sense, 2) <= zero_level)
        else $error("gate rose while primary not near zero");
    AST_GATE_ENDS: assert property ($rose(sr_gate_drive) |-> ##[1:1000] !sr_gate_drive)
        else $error("gate never turned off");
    AST_BLANK: assert property ($rose(sr_gate_drive) |->
        hi_len >= sr_ctrl_pkg::BLANK_MIN_CYC + sr_ctrl_pkg::BLANK_STEP_CYC * blank_set_pin)
        else $error("gate after pulse shorter than blank");
    AST_THRESH: assert property ($changed(dynamic_threshold) |-> dynamic_threshold ==
        ADC_W'((int'($past(primary_sense, 4)) * int'(sr_ctrl_pkg::TH_NUM)) >> 8))
        else $error("threshold not the scaled sample");
    AST_MIN_ON: assert property ($fell(sr_gate_drive) && !fault |-> on_cnt >= sr_ctrl_pkg::MIN_ON_CYC)
        else $error("gate on time below minimum");
    AST_OFF_BLANK: assert property ($rose(sr_gate_drive) |-> off_cnt >= OFF_BLANK_CYC - 1)
        else $error("gate rose inside off blanking");
    AST_FAULT_SET: assert property (ov_cnt >= sr_ctrl_pkg::OVP_CYC + 6 |-> fault)
        else $error("overvoltage not flagged");
    AST_FAULT_GATE: assert property (fault |-> !sr_gate_drive)
        else $error("gate on during fault");
    AST_OUT_LOW: assert property ((output_sense < output_enable_level) [*6] |-> !sr_gate_drive)
        else $error("gate on with output sense low");
    COV_ON: cover property ($rose(sr_gate_drive));
    COV_OFF: cover property ($fell(sr_gate_drive));
    COV_FAULT: cover property ($rose(fault));
endmodule
bind sr_on_time_ctrl sr_on_time_ctrl_sva #(.ADC_W(ADC_W), .OFF_BLANK_CYC(OFF_BLANK_CYC)) u_sva (
    .clk(clk), .rst_n(rst_n), .primary_sense(primary_sense), .output_sense(output_sense),
    .primary_enable_level(primary_enable_level), .output_enable_level(output_enable_level),
    .overvoltage_level(overvoltage_level), .zero_level(zero_level),
    .blank_set_pin(blank_set_pin), .sr_gate_drive(sr_gate_drive), .fault(fault),
    .dynamic_threshold(dynamic_threshold));
`default_nettype wire

/* dv/volt_sec_sr_on_time_control_test.sv */
// Self-checking bench for the rectifier gate controller.
// Assumes the far-side model drives both sense inputs.
`default_nettype none
module volt_sec_sr_on_time_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int OFF_BLK = 80;
    logic clk = 0;
    logic rst_n = 0;
    logic fire = 0;
    logic [9:0] hi_level = 10'h000;
    logic [15:0] hi_len = 16'h0000;
    logic [9:0] out_level = 10'h0c8;
    logic [3:0] blank_code = 4'h1;
    logic [9:0] primary_sense;
    logic [9:0] output_sense;
    logic [9:0] dynamic_threshold;
    logic sr_gate_drive;
    logic fault;
    int failures = 0;
    int check_count = 0;
    int width;
    int delay;
    logic saw_fault;
    sr_on_time_ctrl #(.OFF_BLANK_CYC(OFF_BLK)) u_sr_on_time_ctrl (.clk(clk), .rst_n(rst_n),
        .primary_sense(primary_sense), .output_sense(output_sense),
        .primary_enable_level(10'h040), .output_enable_level(10'h040),
        .overvoltage_level(10'h300), .zero_level(10'h010), .blank_set_pin(blank_code),
        .sr_gate_drive(sr_gate_drive), .fault(fault), .dynamic_threshold(dynamic_threshold));
    sr_far_side u_sr_far_side (.clk(clk), .fire(fire), .hi_level(hi_level), .hi_len(hi_len),
        .out_level(out_level), .primary_sense(primary_sense), .output_sense(output_sense));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One primary pulse; stop early lets the next pulse land in off blanking
    task automatic run_pulse(input logic [9:0] lv, input int len, input logic [9:0] ol,
            input bit stop);
        width = 0;
        delay = -1;
        saw_fault = 0;
        @(posedge clk);
        #1;
        hi_level = lv;
        hi_len = 16'(len);
        out_level = ol;
        fire = 1;
        @(posedge clk);
        #1;
        fire = 0;
        for (int t = 0; t < 1200; t++) begin
            @(posedge clk);
            #1;
            if (sr_gate_drive === 1'b1 && delay < 0)
                delay = t;
            if (sr_gate_drive === 1'b1)
                width++;
            if (fault === 1'b1)
                saw_fault = 1;
            if (stop && delay >= 0 && sr_gate_drive === 1'b0)
                break;
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_normal();
        run_pulse(10'h0c8, 60, 10'h0c8, 0);
        check(delay >= 60 && delay <= 70, 1);
        check(width >= 151 && width <= 227, 1);
        check(dynamic_threshold, 10'h0aa);
        $display("normal cycle done");
    endtask
    task automatic t_ring();
        run_pulse(10'h096, 60, 10'h0c8, 0);
        check(delay < 0, 1);
        $display("ringing rejection done");
    endtask
    task automatic t_short();
        run_pulse(10'h0c8, 25, 10'h0c8, 0);
        check(delay < 0, 1);
        $display("short pulse done");
    endtask
    task automatic t_blank_code();
        blank_code = 4'h3;
        run_pulse(10'h0c8, 50, 10'h0c8, 0);
        check(delay < 0, 1);
        blank_code = 4'h1;
        run_pulse(10'h0c8, 50, 10'h0c8, 0);
        check(delay >= 0, 1);
        $display("blank code done");
    endtask
    task automatic t_out_low();
        run_pulse(10'h0c8, 60, 10'h020, 0);
        check(delay < 0, 1);
        $display("output low done");
    endtask
    task automatic t_off_blank();
        run_pulse(10'h0c8, 60, 10'h0c8, 1);
        check(delay >= 0, 1);
        run_pulse(10'h0c8, 45, 10'h0c8, 0);
        check(delay < 0, 1);
        run_pulse(10'h0c8, 60, 10'h0c8, 0);
        check(delay >= 0, 1);
        $display("off blanking done");
    endtask
    task automatic t_ovp();
        run_pulse(10'h320, 80, 10'h0c8, 0);
        check(saw_fault, 1'b1);
        check(delay < 0, 1);
        $display("overvoltage done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1;
        repeat (10) @(posedge clk);
        t_normal();
        t_ring();
        t_short();
        t_blank_code();
        t_out_low();
        t_off_blank();
        t_ovp();
        end_of_test();
    end
    // About 11k cycles expected; allow well over twice that
    initial begin
        #300000;
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire

/* verilog/sr_ctrl_pkg.sv */
// Constants for the volt-second rectifier on-time controller.
// Assumes a 100 MHz system clock; voltages arrive as unsigned ADC codes.
`default_nettype none
package sr_ctrl_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ADC_W = 10;
    localparam int RAMP_W = 24;
    // Times in ns
    localparam int SAMPLE_NS = 100;
    localparam int MIN_ON_NS = 350;
    localparam int OFF_BLANK_NS = 4350;
    localparam int OVP_NS = 500;
    localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ) / 1000;
    localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int OFF_BLANK_CYC = (OFF_BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int OVP_CYC = (OVP_NS * CLK_MHZ + 999) / 1000;
    // Blanking per blank_set_pin code step, in cycles, plus minimum
    localparam int BLANK_MIN_CYC = 20;
    localparam int BLANK_STEP_CYC = 12;
    // Threshold ratio 85 % as 109/128 ~ scaled: use 218/256
    localparam logic [8:0] TH_NUM = 9'h0da;
    // Gain ratio 4.15 in 1/256 units
    localparam logic [11:0] GAIN_RATIO_Q8 = 12'h426;
    // Saturation point of primary ramp: 0.16 V-us at 1 V full code ADC scale
    localparam logic [RAMP_W-1:0] RAMP_SAT = 24'h3fffff;
    localparam logic [ADC_W-1:0] OVP_LEVEL_RST = 10'h29a;
endpackage
`default_nettype wire

/* verilog/sr_cycle_timer.sv */
// Loadable down-counter, busy while nonzero.
// Assumes start is a one-cycle pulse on the same clock.
`default_nettype none
module sr_cycle_timer #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [W-1:0] load,
    input wire logic abort,
    output logic busy,
    output logic done
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_done;

    always_comb begin
        next_count = count;
        next_done = 1'b0;
        if (abort) begin
            next_count = '0;
        end else if (start) begin
            next_count = load;
        end else if (count != '0) begin
            next_count = count - 1'b1;
            next_done = (count == {{(W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= next_done;
        end
    end

    assign busy = (count != '0);
endmodule
`default_nettype wire

/* verilog/sr_on_time_ctrl.sv */
// Volt-second synchronous rectifier gate controller.
// Assumes comparator inputs and ADC codes arrive asynchronously; the two sense
// codes and blank_set_pin are passed through two flip-flops, the level inputs are not.
`default_nettype none
module sr_on_time_ctrl #(
    parameter int ADC_W = sr_ctrl_pkg::ADC_W,
    parameter int RAMP_W = sr_ctrl_pkg::RAMP_W,
    parameter int OFF_BLANK_CYC = sr_ctrl_pkg::OFF_BLANK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADC_W-1:0] primary_sense,
    input wire logic [ADC_W-1:0] output_sense,
    input wire logic [ADC_W-1:0] primary_enable_level,
    input wire logic [ADC_W-1:0] output_enable_level,
    input wire logic [ADC_W-1:0] overvoltage_level,
    input wire logic [ADC_W-1:0] zero_level,
    input wire logic [3:0] blank_set_pin,
    output logic sr_gate_drive,
    output logic fault,
    output logic [ADC_W-1:0] dynamic_threshold
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [ADC_W-1:0] pri_s1, pri_s2, out_s1, out_s2;
    logic [3:0] blk_s1, blk_s2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pri_s1 <= '0;
            pri_s2 <= '0;
            out_s1 <= '0;
            out_s2 <= '0;
            blk_s1 <= '0;
            blk_s2 <= '0;
        end else begin
            pri_s1 <= primary_sense;
            pri_s2 <= pri_s1;
            out_s1 <= output_sense;
            out_s2 <= out_s1;
            blk_s1 <= blank_set_pin;
            blk_s2 <= blk_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold comparison and edges
    logic above, above_d, rise, fall, near_zero, out_ok;
    assign above = (pri_s2 > primary_enable_level) && (pri_s2 > dynamic_threshold);
    assign near_zero = (pri_s2 <= zero_level);
    assign out_ok = (out_s2 >= output_enable_level);
    assign rise = above && !above_d;
    assign fall = !above && above_d;

    ////////////////////////////////////////////////////////////////////////
    // Cycle state machine
    typedef enum logic [2:0] {IDLE, BLANK, HIGH, WAIT_ZERO, ON, HOLD} state_t;
    state_t state, next_state;

    localparam int CW = 13;
    logic [CW-1:0] blank_cnt, next_blank_cnt;
    logic [7:0] spl_cnt, next_spl_cnt;
    logic [7:0] ovp_cnt, next_ovp_cnt;
    logic [7:0] on_cnt, next_on_cnt;
    logic qualified, next_qualified;
    logic next_fault, next_gate;
    logic [ADC_W-1:0] next_threshold;
    logic [ADC_W+8:0] th_prod;
    logic [RAMP_W-1:0] pri_ramp, next_pri_ramp, out_ramp, next_out_ramp;
    logic [RAMP_W:0] pri_sum, out_sum;
    logic [ADC_W+11:0] out_inc;
    logic off_busy, off_start;
    logic [CW-1:0] blank_len;

    // Blanking set by the external code; short pin gives minimum
    assign blank_len = CW'(sr_ctrl_pkg::BLANK_MIN_CYC
                       + sr_ctrl_pkg::BLANK_STEP_CYC * int'(blk_s2));
    assign th_prod = pri_s2 * sr_ctrl_pkg::TH_NUM;
    // Output ramp scaled down so primary gain is ratio times larger
    // Widened before the shift so large output codes do not wrap
    assign out_inc = (ADC_W+12)'({6'h00, out_s2, 16'h0000}
                     / sr_ctrl_pkg::GAIN_RATIO_Q8);
    assign pri_sum = {1'b0, pri_ramp} + {{(RAMP_W-ADC_W-7){1'b0}}, pri_s2, 8'h00};
    assign out_sum = {1'b0, out_ramp} + (RAMP_W+1)'(out_inc);

    always_comb begin
        next_state = state;
        next_blank_cnt = blank_cnt;
        next_spl_cnt = spl_cnt;
        next_ovp_cnt = ovp_cnt;
        next_on_cnt = on_cnt;
        next_qualified = qualified;
        next_fault = fault;
        next_gate = sr_gate_drive;
        next_threshold = dynamic_threshold;
        next_pri_ramp = pri_ramp;
        next_out_ramp = out_ramp;
        off_start = 1'b0;
        // Overvoltage watch runs every cycle
        if (pri_s2 > overvoltage_level) begin
            if (ovp_cnt < 8'(sr_ctrl_pkg::OVP_CYC)) begin
                next_ovp_cnt = ovp_cnt + 8'h01;
            end else begin
                next_fault = 1'b1;
            end
        end else begin
            next_ovp_cnt = '0;
        end
        // Sample window after blanking
        if (spl_cnt != '0) begin
            next_spl_cnt = spl_cnt - 8'h01;
            if (spl_cnt == 8'h01) begin
                next_threshold = ADC_W'(th_prod >> 8);
            end
        end
        // Ramps run from rise, primary holds after fall
        if (state == BLANK || state == HIGH) begin
            next_pri_ramp = pri_sum[RAMP_W] || pri_sum[RAMP_W-1:0] > sr_ctrl_pkg::RAMP_SAT
                ? sr_ctrl_pkg::RAMP_SAT : pri_sum[RAMP_W-1:0];
        end
        if (state != IDLE) begin
            next_out_ramp = out_sum[RAMP_W] ? '1 : out_sum[RAMP_W-1:0];
        end
        case (state)
            IDLE: begin
            end
            BLANK: begin
                if (!above) begin
                    next_state = IDLE;
                end else if (blank_cnt <= CW'(1)) begin
                    next_qualified = 1'b1;
                    next_spl_cnt = 8'(sr_ctrl_pkg::SAMPLE_CYC);
                    next_state = HIGH;
                end else begin
                    next_blank_cnt = blank_cnt - CW'(1);
                end
            end
            HIGH: begin
                if (fall) begin
                    next_state = WAIT_ZERO;
                end
            end
            WAIT_ZERO: begin
                if (near_zero) begin
                    if (qualified && !next_fault && !off_busy && out_ok) begin
                        next_gate = 1'b1;
                        next_on_cnt = 8'(sr_ctrl_pkg::MIN_ON_CYC);
                        next_state = ON;
                    end else begin
                        next_state = HOLD;
                    end
                end
            end
            ON: begin
                if (on_cnt != '0) begin
                    next_on_cnt = on_cnt - 8'h01;
                end
                // Enable loss and fault override the minimum on time
                if ((on_cnt == '0 && out_ramp >= pri_ramp) || !out_ok || next_fault) begin
                    next_gate = 1'b0;
                    off_start = 1'b1;
                    next_state = HOLD;
                end
            end
            HOLD: begin
            end
            default: next_state = IDLE;
        endcase
        // A new qualifying rise restarts the cycle from any state except BLANK and HIGH
        if (rise && state != BLANK && state != HIGH) begin
            if (sr_gate_drive) begin
                off_start = 1'b1;
            end
            next_gate = 1'b0;
            next_state = BLANK;
            next_blank_cnt = blank_len;
            next_pri_ramp = '0;
            next_out_ramp = '0;
            next_qualified = 1'b0;
            next_fault = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
            blank_cnt <= '0;
            spl_cnt <= '0;
            ovp_cnt <= '0;
            on_cnt <= '0;
            qualified <= 1'b0;
            fault <= 1'b0;
            sr_gate_drive <= 1'b0;
            dynamic_threshold <= '0;
            pri_ramp <= '0;
            out_ramp <= '0;
            above_d <= 1'b0;
        end else begin
            state <= next_state;
            blank_cnt <= next_blank_cnt;
            spl_cnt <= next_spl_cnt;
            ovp_cnt <= next_ovp_cnt;
            on_cnt <= next_on_cnt;
            qualified <= next_qualified;
            fault <= next_fault;
            sr_gate_drive <= next_gate;
            dynamic_threshold <= next_threshold;
            pri_ramp <= next_pri_ramp;
            out_ramp <= next_out_ramp;
            above_d <= above;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Off blanking timer
    sr_cycle_timer #(
        .W(CW)
    ) u_off_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(off_start),
        .load(CW'(OFF_BLANK_CYC)),
        .abort(1'b0),
        .busy(off_busy),
        .done()
    );
endmodule
`default_nettype wire
